// File: pkg/dpw_defs.svh
/*
  Constants of the dual pot wiper register store: widths, reset values,
  instruction codes and timing counts.
  Assumes a 50 MHz system clock; included by its bare name.
*/
`ifndef DPW_DEFS_SVH
`define DPW_DEFS_SVH

// Widths and geometry
`define DPW_POS_W 6
`define DPW_REG_SEL_W 2
`define DPW_ADDR_W 3
`define DPW_NUM_POTS 2
`define DPW_NUM_TAPS 64
`define DPW_NUM_WORDS 8

// Wiper values
`define DPW_POS_RST 6'h00
`define DPW_POS_MIN 6'h00
`define DPW_POS_MAX 6'h3f
`define DPW_POS_ONE 6'h01
`define DPW_TAPS_RST 64'h1

// Instruction codes, upper nibble of the instruction byte
`define DPW_OP_GLD_DR 4'h1
`define DPW_OP_INCDEC 4'h2
`define DPW_OP_GST_POS 4'h8
`define DPW_OP_RD_POS 4'h9
`define DPW_OP_WR_POS 4'ha
`define DPW_OP_RD_DR 4'hb
`define DPW_OP_WR_DR 4'hc
`define DPW_OP_LD_DR 4'hd
`define DPW_OP_ST_POS 4'he

// Timing
`define DPW_CLK_KHZ 50000
`define DPW_T_WR_MS 10
`define DPW_T_PUR_MS 1
`define DPW_T_PUW_MS 5
`define DPW_WR_CYCLES (`DPW_T_WR_MS * `DPW_CLK_KHZ)
`define DPW_PUR_CYCLES (`DPW_T_PUR_MS * `DPW_CLK_KHZ)
`define DPW_PUW_CYCLES (`DPW_T_PUW_MS * `DPW_CLK_KHZ)
`define DPW_CNT_W 20

`endif

// File: pkg/dpw_pkg.sv
/*
  Types of the dual pot wiper register store: instruction codes and the
  controller states.
  Assumes dpw_defs.svh on the include path.
*/
`include "dpw_defs.svh"

package dpw_pkg;

  typedef enum logic [3:0] {
    OP_GLD_DR = `DPW_OP_GLD_DR,
    OP_INCDEC = `DPW_OP_INCDEC,
    OP_GST_POS = `DPW_OP_GST_POS,
    OP_RD_POS = `DPW_OP_RD_POS,
    OP_WR_POS = `DPW_OP_WR_POS,
    OP_RD_DR = `DPW_OP_RD_DR,
    OP_WR_DR = `DPW_OP_WR_DR,
    OP_LD_DR = `DPW_OP_LD_DR,
    OP_ST_POS = `DPW_OP_ST_POS
  } dpw_op_t;

  // Gray steps along recall and from idle through the global store into the write cycle
  typedef enum logic [3:0] {
    ST_RST = 4'h0,
    ST_REC0 = 4'h1,
    ST_REC1 = 4'h3,
    ST_IDLE = 4'h2,
    ST_RDDR = 4'h6,
    ST_LOAD = 4'h7,
    ST_GLOAD0 = 4'h5,
    ST_GLOAD1 = 4'h4,
    ST_GSTORE = 4'ha,
    ST_NVW = 4'hb
  } dpw_state_t;

endpackage

// File: hdl/dpw_store.sv
/*
  Data register array: eight six-bit words, two pots of four.
  One write port, one read port whose data come out of a register one
  cycle after the address. Holds no reset, so contents survive RESET.
*/
`timescale 1ns/10ps
`default_nettype none
`include "dpw_defs.svh"

module dpw_store #(
  parameter int unsigned WIDTH = `DPW_POS_W,
  parameter int unsigned DEPTH = `DPW_NUM_WORDS,
  parameter int unsigned AW = `DPW_ADDR_W
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem_ff [DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_ff[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    rd_data <= mem_ff[rd_addr];
  end

endmodule // dpw_store

`default_nettype wire

// File: hdl/dpw_top.sv
/*
  Dual pot wiper register store: two wiper position counters, eight
  data registers, one-hot tap decode and the nonvolatile write timer.
  Assumes a serial command decoder on SYS_CLK that presents each decoded
  instruction as a one-cycle CMD_VALID and each step clock as STEP_VALID,
  and that withholds its slave acknowledge while BUSY is high.
*/
// How it works
// - Two separate wiper counters, one command port shared by both pots.
// - Six-bit counters, each decoded one-hot onto sixty-four tap outputs.
// - Write-wiper command loads the selected counter with the host value.
// - Transfer command loads the counter from the selected data register.
// - Increment/decrement mode moves the counter one tap per step.
// - After reset both counters are recalled from data register zero.
// - Counters are plain flops; only the data registers keep values.
// - Four data registers per pot, readable and writable by the host.
// - Values move either way between any data register and its counter.
// - Every data register change starts a timed nonvolatile write cycle.
// - Command carries one pot select bit and two register select bits.
// - Each step with data high moves up below tap 63, with data low moves down above tap 0.
// - BUSY withholds acknowledge during a write; host polls until clear.
`timescale 1ns/10ps
`default_nettype none
`include "dpw_defs.svh"

module dpw_top #(
  parameter int unsigned WR_CYCLES = `DPW_WR_CYCLES,
  parameter int unsigned CNT_W = `DPW_CNT_W
) (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic CMD_VALID,
  input wire dpw_pkg::dpw_op_t CMD_OPCODE,
  input wire logic CMD_POT,
  input wire logic [`DPW_REG_SEL_W-1:0] CMD_REG,
  input wire logic [`DPW_POS_W-1:0] CMD_DATA,
  input wire logic STEP_VALID,
  input wire logic STEP_UP,
  output logic BUSY,
  output logic STEP_MODE,
  output logic RD_VALID,
  output logic [`DPW_POS_W-1:0] RD_DATA,
  output logic [`DPW_POS_W-1:0] WIPER0_POS,
  output logic [`DPW_POS_W-1:0] WIPER1_POS,
  output logic [`DPW_NUM_TAPS-1:0] WIPER0_TAPS,
  output logic [`DPW_NUM_TAPS-1:0] WIPER1_TAPS
);

  import dpw_pkg::*;

  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(WR_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;

  dpw_state_t state_ff;
  dpw_state_t nxt_state;

  logic [`DPW_POS_W-1:0] pos_ff [`DPW_NUM_POTS];
  logic [`DPW_NUM_TAPS-1:0] taps_ff [`DPW_NUM_POTS];

  logic pot_ff;
  logic nxt_pot;
  logic [`DPW_REG_SEL_W-1:0] reg_ff;
  logic [`DPW_REG_SEL_W-1:0] nxt_reg;
  logic step_en_ff;
  logic nxt_step_en;
  logic step_pot_ff;
  logic nxt_step_pot;
  logic [CNT_W-1:0] nvw_cnt_ff;
  logic [CNT_W-1:0] nxt_nvw_cnt;
  logic busy_ff;
  logic rd_valid_ff;
  logic nxt_rd_valid;
  logic [`DPW_POS_W-1:0] rd_data_ff;
  logic [`DPW_POS_W-1:0] nxt_rd_data;

  logic [`DPW_ADDR_W-1:0] mem_rd_addr;
  logic [`DPW_POS_W-1:0] mem_rd_data;
  logic mem_wr_en;
  logic [`DPW_ADDR_W-1:0] mem_wr_addr;
  logic [`DPW_POS_W-1:0] mem_wr_data;

  // State decode
  wire st_rst = (state_ff == ST_RST);
  wire st_rec0 = (state_ff == ST_REC0);
  wire st_rec1 = (state_ff == ST_REC1);
  wire st_idle = (state_ff == ST_IDLE);
  wire st_rddr = (state_ff == ST_RDDR);
  wire st_load = (state_ff == ST_LOAD);
  wire st_gload0 = (state_ff == ST_GLOAD0);
  wire st_gload1 = (state_ff == ST_GLOAD1);
  wire st_gstore = (state_ff == ST_GSTORE);
  wire st_nvw = (state_ff == ST_NVW);
  wire nvw_done = st_nvw && (nvw_cnt_ff == CNT_ZERO);

  // Commands are taken only when idle; recall and write cycles drop them
  wire cmd_take = CMD_VALID && st_idle;
  wire op_rd_pos = cmd_take && (CMD_OPCODE == OP_RD_POS);
  wire op_wr_pos = cmd_take && (CMD_OPCODE == OP_WR_POS);
  wire op_rd_dr = cmd_take && (CMD_OPCODE == OP_RD_DR);
  wire op_wr_dr = cmd_take && (CMD_OPCODE == OP_WR_DR);
  wire op_ld_dr = cmd_take && (CMD_OPCODE == OP_LD_DR);
  wire op_st_pos = cmd_take && (CMD_OPCODE == OP_ST_POS);
  wire op_gld_dr = cmd_take && (CMD_OPCODE == OP_GLD_DR);
  wire op_gst_pos = cmd_take && (CMD_OPCODE == OP_GST_POS);
  wire op_incdec = cmd_take && (CMD_OPCODE == OP_INCDEC);

  // Word address is pot select above register select
  wire [`DPW_ADDR_W-1:0] cmd_addr = {CMD_POT, CMD_REG};
  wire rd_pot_one = st_rec0 || st_gload0;
  // Global load starts at pot zero, whatever pot bit came with it
  wire [`DPW_ADDR_W-1:0] idle_rd_addr = op_gld_dr ? {1'b0, CMD_REG} :
                                        cmd_addr;

  // Read port: data return one cycle after the address
  assign mem_rd_addr = st_idle ? idle_rd_addr :
                       st_rst ? 3'h0 :
                       {rd_pot_one, reg_ff};

  // Write port: host data, or a counter copied into a data register
  assign mem_wr_en = op_wr_dr || op_st_pos || op_gst_pos ||
                     st_gstore;
  assign mem_wr_addr = st_gstore ? {1'b1, reg_ff} :
                       op_gst_pos ? {1'b0, CMD_REG} :
                       cmd_addr;
  assign mem_wr_data = st_gstore ? pos_ff[1] :
                       op_wr_dr ? CMD_DATA :
                       op_gst_pos ? pos_ff[0] :
                       pos_ff[CMD_POT];

  dpw_store #(
    .WIDTH(`DPW_POS_W),
    .DEPTH(`DPW_NUM_WORDS),
    .AW(`DPW_ADDR_W)
  ) u_store (
    .clk(SYS_CLK),
    .wr_en(mem_wr_en),
    .wr_addr(mem_wr_addr),
    .wr_data(mem_wr_data),
    .rd_addr(mem_rd_addr),
    .rd_data(mem_rd_data)
  );

  // Controller
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_RST: begin
        nxt_state = ST_REC0;
      end
      ST_REC0: begin
        nxt_state = ST_REC1;
      end
      ST_REC1: begin
        nxt_state = ST_IDLE;
      end
      ST_IDLE: begin
        if (op_rd_dr) begin
          nxt_state = ST_RDDR;
        end else if (op_ld_dr) begin
          nxt_state = ST_LOAD;
        end else if (op_gld_dr) begin
          nxt_state = ST_GLOAD0;
        end else if (op_gst_pos) begin
          nxt_state = ST_GSTORE;
        end else if (op_wr_dr || op_st_pos) begin
          nxt_state = ST_NVW;
        end
      end
      ST_RDDR: begin
        nxt_state = ST_IDLE;
      end
      ST_LOAD: begin
        nxt_state = ST_IDLE;
      end
      ST_GLOAD0: begin
        nxt_state = ST_GLOAD1;
      end
      ST_GLOAD1: begin
        nxt_state = ST_IDLE;
      end
      ST_GSTORE: begin
        nxt_state = ST_NVW;
      end
      ST_NVW: begin
        if (nvw_done) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_RST;
      end
    endcase
  end

  // Write cycle lasts WR_CYCLES clocks from entry
  assign nxt_nvw_cnt = st_nvw ? (nvw_cnt_ff - 1'b1) : CNT_LOAD;

  // Selection captured with each taken command
  assign nxt_pot = cmd_take ? CMD_POT : pot_ff;
  assign nxt_reg = st_rst ? 2'h0 : (cmd_take ? CMD_REG : reg_ff);

  // Step mode lasts until the next command is taken
  assign nxt_step_en = cmd_take ? op_incdec : step_en_ff;
  assign nxt_step_pot = op_incdec ? CMD_POT : step_pot_ff;

  // Read result holds until the next read
  assign nxt_rd_valid = op_rd_pos || st_rddr;
  assign nxt_rd_data = st_rddr ? mem_rd_data :
                       op_rd_pos ? pos_ff[CMD_POT] :
                       rd_data_ff;

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      state_ff <= ST_RST;
      nvw_cnt_ff <= CNT_LOAD;
      pot_ff <= 1'b0;
      reg_ff <= 2'h0;
      step_en_ff <= 1'b0;
      step_pot_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      nvw_cnt_ff <= nxt_nvw_cnt;
      pot_ff <= nxt_pot;
      reg_ff <= nxt_reg;
      step_en_ff <= nxt_step_en;
      step_pot_ff <= nxt_step_pot;
    end
  end

  // Busy follows the state so it rises with the cycle that starts a write
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      busy_ff <= 1'b1;
      rd_valid_ff <= 1'b0;
      rd_data_ff <= `DPW_POS_RST;
    end else begin
      busy_ff <= (nxt_state != ST_IDLE);
      rd_valid_ff <= nxt_rd_valid;
      rd_data_ff <= nxt_rd_data;
    end
  end

  // One counter and tap decoder per pot
  for (genvar p = 0; p < `DPW_NUM_POTS; p++) begin : g_pot
    logic [`DPW_POS_W-1:0] nxt_pos;
    logic recall_hit;
    wire sel_host = (CMD_POT == 1'(p));
    wire load_host = op_wr_pos && sel_host;
    wire step_hit = step_en_ff && STEP_VALID && st_idle && !CMD_VALID &&
                    (step_pot_ff == 1'(p));
    wire at_top = (pos_ff[p] == `DPW_POS_MAX);
    wire at_bot = (pos_ff[p] == `DPW_POS_MIN);
    wire step_inc = step_hit && STEP_UP && !at_top;
    wire step_dec = step_hit && !STEP_UP && !at_bot;

    if (p == 0) begin : g_first
      assign recall_hit = st_rec0 || st_gload0;
    end else begin : g_second
      assign recall_hit = st_rec1 || st_gload1;
    end

    wire load_reg = recall_hit || (st_load && (pot_ff == 1'(p)));

    always_comb begin
      nxt_pos = pos_ff[p];
      if (load_host) begin
        nxt_pos = CMD_DATA;
      end else if (load_reg) begin
        nxt_pos = mem_rd_data;
      end else if (step_inc) begin
        nxt_pos = pos_ff[p] + `DPW_POS_ONE;
      end else if (step_dec) begin
        nxt_pos = pos_ff[p] - `DPW_POS_ONE;
      end
    end

    // Volatile: cleared by reset, then recalled
    // Taps decode the next value so taps and position move together
    always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
        pos_ff[p] <= `DPW_POS_RST;
        taps_ff[p] <= `DPW_TAPS_RST;
      end else begin
        pos_ff[p] <= nxt_pos;
        taps_ff[p] <= `DPW_TAPS_RST << nxt_pos;
      end
    end
  end

  // Every output straight from a flop
  assign BUSY = busy_ff;
  assign STEP_MODE = step_en_ff;
  assign RD_VALID = rd_valid_ff;
  assign RD_DATA = rd_data_ff;
  assign WIPER0_POS = pos_ff[0];
  assign WIPER1_POS = pos_ff[1];
  assign WIPER0_TAPS = taps_ff[0];
  assign WIPER1_TAPS = taps_ff[1];

endmodule // dpw_top

`default_nettype wire

// File: dv/dpw_top_assertions.sv
/*
  Port checker of the dual pot wiper register store.
  Assumes binding to dpw_top, sharing its WR_CYCLES value.
*/
`timescale 1ns/10ps
`default_nettype none

module dpw_top_assertions #(
  parameter int unsigned WR_CYCLES = 8
) (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic CMD_VALID,
  input wire dpw_pkg::dpw_op_t CMD_OPCODE,
  input wire logic CMD_POT,
  input wire logic [5:0] CMD_DATA,
  input wire logic STEP_VALID,
  input wire logic STEP_UP,
  input wire logic BUSY,
  input wire logic STEP_MODE,
  input wire logic RD_VALID,
  input wire logic [5:0] RD_DATA,
  input wire logic [5:0] WIPER0_POS,
  input wire logic [5:0] WIPER1_POS,
  input wire logic [63:0] WIPER0_TAPS,
  input wire logic [63:0] WIPER1_TAPS
);
  import dpw_pkg::*;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  logic step_pot_ff;
  logic nvw_op_ff;
  int busy_cnt_ff;
  wire take = CMD_VALID && !BUSY;
  wire [5:0] sel_pos = step_pot_ff ? WIPER1_POS : WIPER0_POS;
  wire [5:0] step_exp = STEP_UP ?
    (sel_pos == 6'h3f ? sel_pos : sel_pos + 6'h01) :
    (sel_pos == 6'h00 ? sel_pos : sel_pos - 6'h01);
  always_ff @(posedge SYS_CLK) begin
    if (take && CMD_OPCODE == OP_INCDEC) step_pot_ff <= CMD_POT;
    // Busy from a store, not from recall or a load into a counter
    if (RESET) nvw_op_ff <= 1'b0;
    else if (take)
      nvw_op_ff <= CMD_OPCODE inside {OP_WR_DR, OP_ST_POS, OP_GST_POS};
    busy_cnt_ff <= (RESET || !BUSY) ? 0 : busy_cnt_ff + 1;
  end
  property p_taps;
    WIPER0_TAPS == (64'h1 << WIPER0_POS) &&
    WIPER1_TAPS == (64'h1 << WIPER1_POS);
  endproperty
  a_taps: assert property (p_taps) else $error("tap decode");
  property p_wr_pos;
    take && CMD_OPCODE == OP_WR_POS |=>
    ($past(CMD_POT) ? WIPER1_POS : WIPER0_POS) == $past(CMD_DATA);
  endproperty
  a_wr_pos: assert property (p_wr_pos) else $error("wiper write");
  property p_rd_pos;
    take && CMD_OPCODE == OP_RD_POS |=> RD_VALID && RD_DATA ==
    ($past(CMD_POT) ? $past(WIPER1_POS) : $past(WIPER0_POS));
  endproperty
  a_rd_pos: assert property (p_rd_pos) else $error("wiper read");
  property p_rd_dr;
    take && CMD_OPCODE == OP_RD_DR |-> ##2 RD_VALID;
  endproperty
  a_rd_dr: assert property (p_rd_dr) else $error("data read");
  property p_nvw;
    take && CMD_OPCODE inside {OP_WR_DR, OP_ST_POS, OP_GST_POS} |=> BUSY;
  endproperty
  a_nvw: assert property (p_nvw) else $error("store not busy");
  property p_nvw_max;
    busy_cnt_ff <= WR_CYCLES + 1;
  endproperty
  a_nvw_max: assert property (p_nvw_max) else $error("busy too long");
  property p_step;
    STEP_MODE && STEP_VALID && !CMD_VALID |=> sel_pos == $past(step_exp);
  endproperty
  a_step: assert property (p_step) else $error("step");
  property p_mode;
    take && CMD_OPCODE == OP_INCDEC |=> STEP_MODE;
  endproperty
  a_mode: assert property (p_mode) else $error("step mode");
  property p_recall;
    $fell(RESET) |-> BUSY [*3] ##1 !BUSY;
  endproperty
  a_recall: assert property (p_recall) else $error("recall");
  property p_ign;
    BUSY && nvw_op_ff && CMD_VALID |=>
    $stable(WIPER0_POS) && $stable(WIPER1_POS);
  endproperty
  a_ign: assert property (p_ign) else $error("busy command");
endmodule // dpw_top_assertions

bind dpw_top dpw_top_assertions #(.WR_CYCLES(WR_CYCLES)) chk_u (
  .SYS_CLK(SYS_CLK), .RESET(RESET), .CMD_VALID(CMD_VALID),
  .CMD_OPCODE(CMD_OPCODE), .CMD_POT(CMD_POT), .CMD_DATA(CMD_DATA),
  .STEP_VALID(STEP_VALID), .STEP_UP(STEP_UP), .BUSY(BUSY),
  .STEP_MODE(STEP_MODE), .RD_VALID(RD_VALID), .RD_DATA(RD_DATA),
  .WIPER0_POS(WIPER0_POS), .WIPER1_POS(WIPER1_POS),
  .WIPER0_TAPS(WIPER0_TAPS), .WIPER1_TAPS(WIPER1_TAPS));
`default_nettype wire

// File: dv/dpw_host_model.sv
/*
  Command decoder model standing for the host side.
  Assumes the bench top test_dual_pot_wiper_registers with task hang.
*/
`timescale 1ns/10ps
`default_nettype none

module dpw_host_model #(
  parameter int PU_RD = 4,
  parameter int PU_WR = 12
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic busy,
  output logic cmd_valid,
  output var dpw_pkg::dpw_op_t cmd_op,
  output logic cmd_pot,
  output logic [1:0] cmd_reg,
  output logic [5:0] cmd_data,
  output logic step_valid,
  output logic step_up
);
  import dpw_pkg::*;
  int up_cnt = 0;
  initial begin
    cmd_valid = 0;
    cmd_op = OP_RD_POS;
    {cmd_pot, cmd_reg, cmd_data, step_valid, step_up} = '0;
  end
  always @(posedge clk) up_cnt <= reset ? 0 : up_cnt + 1;
  task automatic cmd(input dpw_op_t op, input logic p, input logic [1:0] r,
                     input logic [5:0] d, input bit raw);
    int need;
    int i;
    need = (op == OP_RD_POS || op == OP_RD_DR) ? PU_RD : PU_WR;
    @(negedge clk);
    if (!raw) begin
      @(negedge clk);
      for (i = 0; i < 200 && (busy || up_cnt < need); i++) @(negedge clk);
      if (busy || up_cnt < need) test_dual_pot_wiper_registers.hang;
    end
    cmd_valid <= 1;
    cmd_op <= op;
    {cmd_pot, cmd_reg, cmd_data} <= {p, r, d};
    @(negedge clk);
    cmd_valid <= 0;
    cmd_data <= ~d;
  endtask
  task automatic step(input logic up);
    step_valid <= 1;
    step_up <= up;
    @(negedge clk);
    step_valid <= 0;
    step_up <= ~up;
    @(negedge clk);
  endtask
endmodule // dpw_host_model
`default_nettype wire

// File: dv/test_dual_pot_wiper_registers.sv
/*
  Self-checking bench of the dual pot wiper register store.
  Assumes dpw_top, dpw_host_model and the bound port checker.
*/
`timescale 1ns/10ps
`default_nettype none

`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin \
  num_errors++; $display("wrong value at %0t: %h %h", $time, got, exp); \
  end end

module test_dual_pot_wiper_registers;
  import dpw_pkg::*;
  logic sys_clk = 0;
  logic reset = 1;
  logic cmd_valid, cmd_pot, step_valid, step_up;
  dpw_op_t cmd_op;
  logic [1:0] cmd_reg;
  logic [5:0] cmd_data, rd_data, w0_pos, w1_pos;
  logic busy, step_mode, rd_valid;
  logic [63:0] w0_taps, w1_taps;
  int num_errors = 0;
  int tests_run = 0;
  always #10 sys_clk = ~sys_clk;
  dpw_top #(.WR_CYCLES(8), .CNT_W(20)) dut_u (
    .SYS_CLK(sys_clk), .RESET(reset), .CMD_VALID(cmd_valid),
    .CMD_OPCODE(cmd_op), .CMD_POT(cmd_pot), .CMD_REG(cmd_reg),
    .CMD_DATA(cmd_data), .STEP_VALID(step_valid), .STEP_UP(step_up),
    .BUSY(busy), .STEP_MODE(step_mode), .RD_VALID(rd_valid),
    .RD_DATA(rd_data), .WIPER0_POS(w0_pos), .WIPER1_POS(w1_pos),
    .WIPER0_TAPS(w0_taps), .WIPER1_TAPS(w1_taps));
  dpw_host_model host_u (
    .clk(sys_clk), .reset(reset), .busy(busy), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_pot(cmd_pot), .cmd_reg(cmd_reg),
    .cmd_data(cmd_data), .step_valid(step_valid), .step_up(step_up));
  task automatic conclude;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic hang;
    num_errors++;
    conclude;
  endtask
  task automatic rd(input dpw_op_t op, input logic p, input logic [1:0] r,
                    input logic [5:0] e);
    int i;
    host_u.cmd(op, p, r, 6'h00, 0);
    for (i = 0; i < 4 && rd_valid !== 1'b1; i++) @(negedge sys_clk);
    `CHK(rd_valid, 1'b1)
    `CHK(rd_data, e)
  endtask
  task automatic sc_wiper;
    host_u.cmd(OP_WR_POS, 0, 0, 6'h2a, 0);
    host_u.cmd(OP_WR_POS, 1, 0, 6'h15, 0);
    `CHK(w0_pos, 6'h2a)
    `CHK(w1_pos, 6'h15)
    `CHK(w0_taps, 64'h1 << 6'h2a)
    `CHK(w1_taps, 64'h1 << 6'h15)
    rd(OP_RD_POS, 0, 0, 6'h2a);
  endtask
  task automatic sc_data;
    int a;
    for (a = 0; a < 8; a++) begin
      host_u.cmd(OP_WR_DR, a[2], a[1:0], 6'h30 + 6'(a), 0);
      `CHK(busy, 1'b1)
    end
    for (a = 0; a < 8; a++) rd(OP_RD_DR, a[2], a[1:0], 6'h30 + 6'(a));
    host_u.cmd(OP_LD_DR, 1, 2, 6'h00, 0);
    @(negedge sys_clk);
    `CHK(w1_pos, 6'h36)
    host_u.cmd(OP_ST_POS, 0, 3, 6'h00, 0);
    host_u.cmd(OP_WR_POS, 0, 0, 6'h01, 1);
    `CHK(w0_pos, 6'h2a)
    rd(OP_RD_DR, 0, 3, 6'h2a);
  endtask
  task automatic sc_global;
    host_u.cmd(OP_GST_POS, 0, 1, 6'h00, 0);
    rd(OP_RD_DR, 1, 1, 6'h36);
    host_u.cmd(OP_WR_POS, 0, 0, 6'h00, 0);
    host_u.cmd(OP_GLD_DR, 1, 1, 6'h00, 0);
    repeat (2) @(negedge sys_clk);
    `CHK(w0_pos, 6'h2a)
    `CHK(w1_pos, 6'h36)
  endtask
  task automatic sc_step;
    host_u.cmd(OP_WR_POS, 1, 0, 6'h3e, 0);
    host_u.cmd(OP_INCDEC, 1, 0, 6'h00, 0);
    `CHK(step_mode, 1'b1)
    repeat (2) host_u.step(1);
    `CHK(w1_pos, 6'h3f)
    host_u.step(0);
    `CHK(w1_pos, 6'h3e)
    `CHK(w0_pos, 6'h2a)
    host_u.cmd(OP_WR_POS, 0, 0, 6'h00, 0);
    host_u.cmd(OP_INCDEC, 0, 0, 6'h00, 0);
    host_u.step(0);
    `CHK(w0_pos, 6'h00)
  endtask
  task automatic sc_recall;
    reset = 1;
    repeat (6) @(negedge sys_clk);
    `CHK(w0_pos, 6'h00)
    reset = 0;
    repeat (4) @(negedge sys_clk);
    `CHK(w0_pos, 6'h30)
    `CHK(w1_pos, 6'h34)
  endtask
  initial begin
    repeat (6) @(negedge sys_clk);
    reset = 0;
    sc_wiper;
    sc_data;
    sc_global;
    sc_step;
    sc_recall;
    conclude;
  end
endmodule // test_dual_pot_wiper_registers
`default_nettype wire
